// ==== common/spp_link_if.sv ====
// Parallel link between the MAC end and the PHY end
`timescale 1ns/100ps
interface spp_link_if;
   import spp_pkg::*;
   // Transmit direction, MAC to PHY, on mac_tx_clock
   logic mac_tx_clock;
   logic [BYTE_W-1:0] tx_byte;
   logic tx_is_ctrl_symbol;
   logic detect_or_loopback_cmd;
   logic tx_elec_idle_cmd;
   logic compliance_neg_disparity;
   logic rx_invert_polarity;
   logic power_state_bit0;
   logic power_state_bit1;
   logic phy_reset_n;
   // Receive direction, PHY to MAC, on phy_rx_clock except rx_elec_idle_seen, which follows the core clock
   logic phy_rx_clock;
   logic [BYTE_W-1:0] rx_byte;
   logic rx_is_ctrl_symbol;
   logic rx_symbols_valid;
   logic op_done_flag;
   logic rx_elec_idle_seen;
   logic rx_status_code_b0;
   logic rx_status_code_b1;
   logic rx_status_code_b2;

   modport mac (
      output mac_tx_clock, tx_byte, tx_is_ctrl_symbol,
      output detect_or_loopback_cmd, tx_elec_idle_cmd,
      output compliance_neg_disparity, rx_invert_polarity,
      output power_state_bit0, power_state_bit1, phy_reset_n,
      input phy_rx_clock, rx_byte, rx_is_ctrl_symbol, rx_symbols_valid,
      input op_done_flag, rx_elec_idle_seen,
      input rx_status_code_b0, rx_status_code_b1, rx_status_code_b2
   );
   modport phy (
      input mac_tx_clock, tx_byte, tx_is_ctrl_symbol,
      input detect_or_loopback_cmd, tx_elec_idle_cmd,
      input compliance_neg_disparity, rx_invert_polarity,
      input power_state_bit0, power_state_bit1, phy_reset_n,
      output phy_rx_clock, rx_byte, rx_is_ctrl_symbol, rx_symbols_valid,
      output op_done_flag, rx_elec_idle_seen,
      output rx_status_code_b0, rx_status_code_b1, rx_status_code_b2
   );
endinterface

// ==== common/spp_pkg.sv ====
// Shared constants for the parallel PHY/MAC port, both ends
package spp_pkg;
   // Link word width and power-state codes
   localparam int BYTE_W = 8;
   localparam int PS_W = 2;
   localparam int ST_W = 3;
   localparam logic [1:0] PS_ACTIVE = 2'h0;
   localparam logic [1:0] PS_LIGHT = 2'h1;
   localparam logic [1:0] PS_DEEP = 2'h2;
   localparam logic [1:0] PS_OFF = 2'h3;
   localparam logic [1:0] PS_RESET = PS_DEEP;
   // Receive status codes
   localparam logic [2:0] RXST_OK = 3'h0;
   localparam logic [2:0] RXST_PRESENT = 3'h3;
   // Core clock and timing
   localparam int CLK_MHZ = 200;
   localparam int STAB_US = 64;
   localparam int STAB_CYC = STAB_US * CLK_MHZ;
   localparam int DET_NS = 100;
   localparam int DET_CYC = (DET_NS * CLK_MHZ) / 1000;
   // Link clock half periods in core cycles (run rate vs 10 MHz settling rate)
   localparam int PHY_RX_CLOCK_HALF_RUN = 4;
   localparam int PHY_RX_CLOCK_HALF_STAB = 10;
   localparam int MAC_TX_CLOCK_HALF = 4;
   localparam int DIV_W = 4;
endpackage

// ==== hdl/spp_mac_end.sv ====
// MAC end of the parallel link: drives transmit clock, captures receive
`timescale 1ns/100ps
module spp_mac_end import spp_pkg::*; (
   // Core clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   spp_link_if.mac lnk,
   // User transmit side
   input wire logic [BYTE_W-1:0] u_tx_byte,
   input wire logic u_tx_ctrl,
   input wire logic u_tx_valid,
   output logic u_tx_taken,
   // User commands
   input wire logic [PS_W-1:0] u_power_state,
   input wire logic u_detect,
   input wire logic u_tx_idle,
   input wire logic u_compliance,
   input wire logic u_rx_invert,
   input wire logic u_phy_reset,
   // User receive side
   output logic [BYTE_W-1:0] u_rx_byte,
   output logic u_rx_ctrl,
   output logic u_rx_valid,
   output logic u_rx_strobe,
   output logic u_op_done,
   output logic [ST_W-1:0] u_rx_status,
   output logic u_rx_elec_idle
);
   logic [DIV_W-1:0] div_r;
   logic mac_tx_clock_r;
   logic fall_tick;
   logic in_reset;
   logic stby;
   logic rrst_s1, rrst_s2;
   logic [BYTE_W-1:0] cap_byte_r;
   logic cap_ctrl_r, cap_valid_r, cap_done_r;
   logic [ST_W-1:0] cap_st_r;
   logic cap_tog_r;
   logic tog_s1, tog_s2, tog_s3;
   logic idle_s1, idle_s2;

   // Transmit clock divider; data changes on falling edge
   assign fall_tick = (div_r == DIV_W'(MAC_TX_CLOCK_HALF - 1)) && mac_tx_clock_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         div_r <= '0;
         mac_tx_clock_r <= 1'b0;
      end else if (div_r == DIV_W'(MAC_TX_CLOCK_HALF - 1)) begin
         div_r <= '0;
         mac_tx_clock_r <= ~mac_tx_clock_r;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end
   assign lnk.mac_tx_clock = mac_tx_clock_r;

   // Transmit byte and commands, one byte per link cycle
   assign in_reset = rst || u_phy_reset;
   assign stby = (u_power_state == PS_LIGHT) || (u_power_state == PS_DEEP);
   always_ff @(posedge clk) begin
      if (rst) begin
         lnk.tx_byte <= '0;
         lnk.tx_is_ctrl_symbol <= 1'b0;
         lnk.detect_or_loopback_cmd <= 1'b0;
         lnk.tx_elec_idle_cmd <= 1'b1;
         lnk.compliance_neg_disparity <= 1'b0;
         lnk.rx_invert_polarity <= 1'b0;
         {lnk.power_state_bit1, lnk.power_state_bit0} <= PS_RESET;
         lnk.phy_reset_n <= 1'b0;
         u_tx_taken <= 1'b0;
      end else begin
         u_tx_taken <= fall_tick && u_tx_valid && !in_reset;
         if (fall_tick) begin
            lnk.tx_byte <= u_tx_valid ? u_tx_byte : '0;
            lnk.tx_is_ctrl_symbol <= u_tx_valid && u_tx_ctrl;
            lnk.phy_reset_n <= !in_reset;
            lnk.detect_or_loopback_cmd <= !in_reset && u_detect;
            lnk.tx_elec_idle_cmd <= in_reset || u_tx_idle || stby;
            lnk.compliance_neg_disparity <= !in_reset && u_compliance;
            lnk.rx_invert_polarity <= !in_reset && u_rx_invert;
            {lnk.power_state_bit1, lnk.power_state_bit0} <=
               in_reset ? PS_RESET : u_power_state;
         end
      end
   end

   // Receive domain reset, from the held-low PHY reset line
   // The receive clock is stopped while rst is high, so rst itself
   // would never reach this domain; the PHY reset spans live edges
   always_ff @(posedge lnk.phy_rx_clock) begin
      rrst_s1 <= !lnk.phy_reset_n;
      rrst_s2 <= rrst_s1;
   end

   // Capture receive word on rising receive clock, toggle per word
   always_ff @(posedge lnk.phy_rx_clock) begin
      if (rrst_s2) begin
         cap_byte_r <= '0;
         cap_ctrl_r <= 1'b0;
         cap_valid_r <= 1'b0;
         cap_done_r <= 1'b0;
         cap_st_r <= RXST_OK;
         cap_tog_r <= 1'b0;
      end else begin
         cap_byte_r <= lnk.rx_byte;
         cap_ctrl_r <= lnk.rx_is_ctrl_symbol;
         cap_valid_r <= lnk.rx_symbols_valid;
         cap_done_r <= lnk.op_done_flag;
         cap_st_r <= {lnk.rx_status_code_b2, lnk.rx_status_code_b1,
                      lnk.rx_status_code_b0};
         cap_tog_r <= ~cap_tog_r;
      end
   end

   // Toggle and idle synchronisers into core domain
   always_ff @(posedge clk) begin
      tog_s1 <= cap_tog_r;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      idle_s1 <= lnk.rx_elec_idle_seen;
      idle_s2 <= idle_s1;
   end

   // Hand captured word to user once toggle changes
   always_ff @(posedge clk) begin
      if (rst) begin
         u_rx_byte <= '0;
         u_rx_ctrl <= 1'b0;
         u_rx_valid <= 1'b0;
         u_rx_strobe <= 1'b0;
         u_op_done <= 1'b0;
         u_rx_status <= RXST_OK;
         u_rx_elec_idle <= 1'b0;
      end else begin
         u_rx_strobe <= tog_s2 != tog_s3;
         u_op_done <= (tog_s2 != tog_s3) && cap_done_r;
         u_rx_elec_idle <= idle_s2;
         if (tog_s2 != tog_s3) begin
            u_rx_byte <= cap_byte_r;
            u_rx_ctrl <= cap_ctrl_r;
            u_rx_valid <= cap_valid_r;
            u_rx_status <= cap_st_r;
         end
      end
   end
endmodule

// ==== hdl/spp_phy_end.sv ====
// PHY end of the parallel link: transmit capture, receive clock and status
`timescale 1ns/100ps
module spp_phy_end import spp_pkg::*; #(
   parameter int STAB_CYCLES = STAB_CYC,
   parameter int DET_CYCLES = DET_CYC
) (
   // Core clock, stands for the reference-derived clock
   input wire logic clk,
   input wire logic rst,
   // Link
   spp_link_if.phy lnk,
   // Line receive side, asynchronous pins
   input wire logic [BYTE_W-1:0] line_rx_byte,
   input wire logic line_rx_ctrl,
   input wire logic line_rx_lock,
   input wire logic line_rx_idle,
   input wire logic line_rx_present,
   input wire logic [ST_W-1:0] line_rx_err,
   // Line transmit side
   output logic [BYTE_W-1:0] line_tx_byte,
   output logic line_tx_ctrl,
   output logic line_tx_idle,
   output logic line_tx_disp_neg,
   output logic line_loopback
);
   // Refuse counts that the settle and detect counters cannot serve
   if (STAB_CYCLES < 1 || DET_CYCLES < 1) begin : g_bad_counts
      $error("spp_phy_end: cycle counts must be at least one");
   end

   typedef enum logic [1:0] {
      ST_STAB = 2'b00,
      ST_RUN = 2'b01,
      ST_DETECT = 2'b10
   } spp_state_type;

   // Transmit domain
   logic [BYTE_W-1:0] t_byte_r;
   logic t_ctrl_r, t_det_r, t_idle_r, t_comp_r, t_rstn_r;
   logic [PS_W-1:0] t_ps_r;
   logic [BYTE_W-1:0] tl_byte_s1, tl_byte_s2;
   logic tl_ctrl_s1, tl_ctrl_s2;
   // Core domain
   logic rstn_s1, rstn_s2, det_s1, det_s2, pol_s1, pol_s2;
   logic [PS_W-1:0] ps_s1, ps_s2;
   logic [BYTE_W-1:0] lb_s1, lb_s2;
   logic lc_s1, lc_s2, lk_s1, lk_s2, li_s1, li_s2, lp_s1, lp_s2;
   logic [ST_W-1:0] le_s1, le_s2;
   logic core_rst;
   spp_state_type state_r, state_nxt;
   logic [31:0] cnt_r;
   logic det_prev_r;
   logic [PS_W-1:0] ps_prev_r;
   logic done_pend_r, det_pend_r, det_res_r;
   logic [DIV_W-1:0] div_r;
   logic phy_rx_clock_r;
   logic [DIV_W-1:0] half;
   logic fall_tick;
   logic done_set, det_set;

   // Capture inputs on rising transmit clock
   always_ff @(posedge lnk.mac_tx_clock) begin
      t_byte_r <= lnk.tx_byte;
      t_ctrl_r <= lnk.tx_is_ctrl_symbol;
      t_det_r <= lnk.detect_or_loopback_cmd;
      t_idle_r <= lnk.tx_elec_idle_cmd;
      t_comp_r <= lnk.compliance_neg_disparity;
      t_ps_r <= {lnk.power_state_bit1, lnk.power_state_bit0};
      t_rstn_r <= lnk.phy_reset_n;
      tl_byte_s1 <= line_rx_byte;
      tl_byte_s2 <= tl_byte_s1;
      tl_ctrl_s1 <= line_rx_ctrl;
      tl_ctrl_s2 <= tl_ctrl_s1;
   end

   // Line transmit: idle, disparity, loopback of received stream
   always_ff @(posedge lnk.mac_tx_clock) begin
      if (!t_rstn_r) begin
         line_tx_byte <= '0;
         line_tx_ctrl <= 1'b0;
         line_tx_idle <= 1'b1;
         line_tx_disp_neg <= 1'b0;
         line_loopback <= 1'b0;
      end else begin
         line_loopback <= t_det_r && (t_ps_r == PS_ACTIVE);
         line_tx_byte <= line_loopback ? tl_byte_s2 : t_byte_r;
         line_tx_ctrl <= line_loopback ? tl_ctrl_s2 : t_ctrl_r;
         line_tx_idle <= t_idle_r && !line_loopback;
         line_tx_disp_neg <= t_comp_r;
      end
   end

   // Synchronisers into core domain
   always_ff @(posedge clk) begin
      rstn_s1 <= t_rstn_r;
      rstn_s2 <= rstn_s1;
      det_s1 <= t_det_r;
      det_s2 <= det_s1;
      pol_s1 <= lnk.rx_invert_polarity;
      pol_s2 <= pol_s1;
      ps_s1 <= t_ps_r;
      ps_s2 <= ps_s1;
      lb_s1 <= line_rx_byte;
      lb_s2 <= lb_s1;
      lc_s1 <= line_rx_ctrl;
      lc_s2 <= lc_s1;
      lk_s1 <= line_rx_lock;
      lk_s2 <= lk_s1;
      li_s1 <= line_rx_idle;
      li_s2 <= li_s1;
      lp_s1 <= line_rx_present;
      lp_s2 <= lp_s1;
      le_s1 <= line_rx_err;
      le_s2 <= le_s1;
   end
   assign core_rst = rst || !rstn_s2;

   // Receive clock divider, slow until clocks settle
   assign half = (state_r == ST_STAB) ? DIV_W'(PHY_RX_CLOCK_HALF_STAB)
                                      : DIV_W'(PHY_RX_CLOCK_HALF_RUN);
   assign fall_tick = (div_r >= half - 1'b1) && phy_rx_clock_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         div_r <= '0;
         phy_rx_clock_r <= 1'b0;
      end else if (div_r >= half - 1'b1) begin
         div_r <= '0;
         phy_rx_clock_r <= ~phy_rx_clock_r;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end
   assign lnk.phy_rx_clock = phy_rx_clock_r;

   // Operation state: settle, run, receiver detection
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_STAB: begin
            if (cnt_r >= 32'(STAB_CYCLES - 1)) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (det_s2 && !det_prev_r && ps_s2 == PS_DEEP) begin
               state_nxt = ST_DETECT;
            end
         end
         ST_DETECT: begin
            if (cnt_r >= 32'(DET_CYCLES - 1)) begin
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_STAB;
      endcase
   end
   always_ff @(posedge clk) begin
      if (core_rst) begin
         state_r <= ST_STAB;
         cnt_r <= '0;
         det_prev_r <= 1'b0;
         ps_prev_r <= PS_RESET;
      end else begin
         state_r <= state_nxt;
         cnt_r <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
         det_prev_r <= det_s2;
         ps_prev_r <= ps_s2;
      end
   end

   // Pending completions; a new event wins over the clear at a tick
   assign det_set = (state_r == ST_DETECT) && (state_nxt == ST_RUN);
   assign done_set = det_set ||
      ((state_r == ST_RUN) && (ps_s2 != ps_prev_r));
   always_ff @(posedge clk) begin
      if (core_rst) begin
         done_pend_r <= 1'b0;
         det_pend_r <= 1'b0;
         det_res_r <= 1'b0;
      end else begin
         done_pend_r <= done_set || (done_pend_r && !fall_tick);
         det_pend_r <= det_set || (det_pend_r && !fall_tick);
         if (det_set) begin
            det_res_r <= lp_s2;
         end
      end
   end

   // Receive outputs change at falling receive clock, once per cycle
   always_ff @(posedge clk) begin
      if (core_rst) begin
         lnk.rx_byte <= '0;
         lnk.rx_is_ctrl_symbol <= 1'b0;
         lnk.rx_symbols_valid <= 1'b0;
         lnk.op_done_flag <= 1'b1;
         {lnk.rx_status_code_b2, lnk.rx_status_code_b1,
          lnk.rx_status_code_b0} <= RXST_OK;
      end else if (fall_tick) begin
         lnk.rx_byte <= pol_s2 ? ~lb_s2 : lb_s2;
         lnk.rx_is_ctrl_symbol <= lc_s2;
         lnk.rx_symbols_valid <= lk_s2 && (state_r != ST_STAB) &&
                                 (ps_s2 == PS_ACTIVE);
         lnk.op_done_flag <= (state_r == ST_STAB) || done_pend_r;
         {lnk.rx_status_code_b2, lnk.rx_status_code_b1,
          lnk.rx_status_code_b0} <= det_pend_r ?
            (det_res_r ? RXST_PRESENT : RXST_OK) :
            (lk_s2 ? le_s2 : RXST_OK);
      end
   end

   // Electrical idle passed on after the pin synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         lnk.rx_elec_idle_seen <= 1'b0;
      end else begin
         lnk.rx_elec_idle_seen <= li_s2;
      end
   end
endmodule

// ==== verif/serial_phy_mac_parallel_port_tb.sv ====
// Bench joining the MAC end and the PHY end over the link
`timescale 1ns/100ps
module serial_phy_mac_parallel_port_tb;
   import spp_pkg::*;
   localparam int STAB_SIM = 50;
   localparam int LIMIT = 20000;
   // Core clock and reset
   logic clk = 1'b0;
   logic rst = 1'b1;
   // MAC user side
   logic [7:0] u_tx_byte = 8'h00;
   logic u_tx_ctrl = 1'b0, u_tx_valid = 1'b0, u_tx_taken;
   logic [1:0] u_power_state = PS_RESET;
   logic u_detect = 1'b0, u_tx_idle = 1'b1, u_compliance = 1'b0;
   logic u_rx_invert = 1'b0, u_phy_reset = 1'b1;
   logic [7:0] u_rx_byte;
   logic u_rx_ctrl, u_rx_valid, u_rx_strobe, u_op_done, u_rx_elec_idle;
   logic [2:0] u_rx_status;
   // PHY line side
   logic [7:0] line_rx_byte = 8'h00;
   logic line_rx_ctrl = 1'b0, line_rx_lock = 1'b0, line_rx_idle = 1'b0;
   logic line_rx_present = 1'b0;
   logic [2:0] line_rx_err = 3'h0;
   logic [7:0] line_tx_byte;
   logic line_tx_ctrl, line_tx_idle, line_tx_disp_neg, line_loopback;
   int fail_count = 0, comparisons = 0, cycles = 0, k;
   logic got;
   logic [7:0] per;

   spp_link_if lnk ();
   spp_mac_end i_spp_mac_end (.clk(clk), .rst(rst), .lnk(lnk),
      .u_tx_byte(u_tx_byte), .u_tx_ctrl(u_tx_ctrl), .u_tx_valid(u_tx_valid),
      .u_tx_taken(u_tx_taken), .u_power_state(u_power_state),
      .u_detect(u_detect), .u_tx_idle(u_tx_idle),
      .u_compliance(u_compliance), .u_rx_invert(u_rx_invert),
      .u_phy_reset(u_phy_reset), .u_rx_byte(u_rx_byte),
      .u_rx_ctrl(u_rx_ctrl), .u_rx_valid(u_rx_valid),
      .u_rx_strobe(u_rx_strobe), .u_op_done(u_op_done),
      .u_rx_status(u_rx_status), .u_rx_elec_idle(u_rx_elec_idle));
   spp_phy_end #(.STAB_CYCLES(STAB_SIM)) i_spp_phy_end (.clk(clk),
      .rst(rst), .lnk(lnk), .line_rx_byte(line_rx_byte),
      .line_rx_ctrl(line_rx_ctrl), .line_rx_lock(line_rx_lock),
      .line_rx_idle(line_rx_idle), .line_rx_present(line_rx_present),
      .line_rx_err(line_rx_err), .line_tx_byte(line_tx_byte),
      .line_tx_ctrl(line_tx_ctrl), .line_tx_idle(line_tx_idle),
      .line_tx_disp_neg(line_tx_disp_neg), .line_loopback(line_loopback));
   spp_link_monitor #(.STAB_CYCLES(STAB_SIM)) i_spp_link_monitor (
      .rst(rst), .mac_tx_clock(lnk.mac_tx_clock),
      .detect_or_loopback_cmd(lnk.detect_or_loopback_cmd),
      .tx_elec_idle_cmd(lnk.tx_elec_idle_cmd),
      .power_state_bit0(lnk.power_state_bit0),
      .power_state_bit1(lnk.power_state_bit1),
      .phy_reset_n(lnk.phy_reset_n), .phy_rx_clock(lnk.phy_rx_clock),
      .rx_symbols_valid(lnk.rx_symbols_valid),
      .op_done_flag(lnk.op_done_flag));

   // Core clock
   always #2.5 clk = ~clk;
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         close_out();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bounded wait for a completion pulse at the MAC end
   task automatic wait_done(output logic g);
      int n;
      n = 0;
      g = 1'b0;
      while (!g && n < 400) begin
         @(posedge clk);
         n++;
         g = (u_op_done === 1'b1);
      end
   endtask
   // Receive clock period in core cycles
   task automatic rx_period(output logic [7:0] n);
      realtime t;
      @(posedge lnk.phy_rx_clock);
      t = $realtime;
      @(posedge lnk.phy_rx_clock);
      n = 8'(int'(($realtime - t) / 5.0));
   endtask
   // One byte through the transmit path
   task automatic send_tx(input logic [7:0] b, input logic c);
      int n;
      n = 0;
      @(posedge clk);
      u_tx_byte <= b;
      u_tx_ctrl <= c;
      u_tx_valid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (u_tx_taken !== 1'b1 && n < 100);
      u_tx_valid <= 1'b0;
      @(posedge lnk.mac_tx_clock);
      @(posedge lnk.mac_tx_clock);
      @(negedge lnk.mac_tx_clock);
      check(line_tx_byte, b);
      check({7'h00, line_tx_ctrl}, {7'h00, c});
   endtask
   // Line word in, f is {idle, invert, lock, ctrl}
   task automatic rx_word(input logic [7:0] b, input logic [3:0] f,
      input logic [2:0] e);
      @(posedge clk);
      line_rx_byte <= b;
      line_rx_ctrl <= f[0];
      line_rx_lock <= f[1];
      u_rx_invert <= f[2];
      line_rx_idle <= f[3];
      line_rx_err <= e;
      ticks(80);
      check({7'h00, u_rx_valid}, {7'h00, f[1]});
      check({7'h00, u_rx_elec_idle}, {7'h00, f[3]});
      if (f[1]) begin
         check(u_rx_byte, f[2] ? ~b : b);
         check(lnk.rx_byte, f[2] ? ~b : b);
         check({7'h00, u_rx_ctrl}, {7'h00, f[0]});
         check({5'h00, u_rx_status}, {5'h00, e});
      end
   endtask

   initial begin
      ticks(3);
      rst <= 1'b0;
      ticks(40);
      check(8'({lnk.power_state_bit1, lnk.power_state_bit0}), 8'h02);
      check({7'h00, lnk.detect_or_loopback_cmd}, 8'h00);
      check({7'h00, line_tx_idle}, 8'h01);
      check({7'h00, lnk.op_done_flag}, 8'h01);
      rx_period(per);
      check(per, 8'(2 * PHY_RX_CLOCK_HALF_STAB));
      u_phy_reset <= 1'b0;
      ticks(20);
      check({7'h00, lnk.op_done_flag}, 8'h01);
      for (k = 0; k < 1000 && lnk.op_done_flag !== 1'b0; k++) begin
         @(posedge clk);
      end
      check({7'h00, lnk.op_done_flag}, 8'h00);
      ticks(20);
      u_power_state <= PS_ACTIVE;
      u_tx_idle <= 1'b0;
      wait_done(got);
      check({7'h00, got}, 8'h01);
      check({7'h00, u_rx_strobe}, 8'h01);
      rx_period(per);
      check(per, 8'(2 * PHY_RX_CLOCK_HALF_RUN));
      $display("Test reset and settling finished");
      send_tx(8'h3e, 1'b0);
      send_tx(8'hbc, 1'b1);
      send_tx(8'hff, 1'b0);
      send_tx(8'h5a, 1'b1);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         u_tx_idle <= i[0];
         u_compliance <= i[1];
         ticks(40);
         check({7'h00, line_tx_idle}, {7'h00, i[0]});
         check({7'h00, line_tx_disp_neg}, {7'h00, i[1]});
      end
      u_tx_idle <= 1'b0;
      u_compliance <= 1'b0;
      $display("Test transmit finished");
      rx_word(8'h3c, 4'b0010, 3'h0);
      rx_word(8'hbc, 4'b0011, 3'h4);
      rx_word(8'h0f, 4'b0110, 3'h0);
      rx_word(8'ha5, 4'b1000, 3'h0);
      $display("Test receive finished");
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         u_tx_idle <= 1'b1;
         u_power_state <= PS_DEEP;
         line_rx_present <= p[0];
         wait_done(got);
         check({7'h00, got}, 8'h01);
         ticks(60);
         u_detect <= 1'b1;
         wait_done(got);
         check({7'h00, got}, 8'h01);
         check(8'(u_rx_status), 8'(p[0] ? RXST_PRESENT : RXST_OK));
         u_detect <= 1'b0;
         ticks(60);
         u_power_state <= PS_ACTIVE;
         u_tx_idle <= 1'b0;
         wait_done(got);
         ticks(60);
      end
      u_detect <= 1'b1;
      ticks(60);
      check({7'h00, line_loopback}, 8'h01);
      u_detect <= 1'b0;
      ticks(60);
      check({7'h00, line_loopback}, 8'h00);
      $display("Test detect and loopback finished");
      close_out();
   end
endmodule

// ==== verif/spp_link_monitor.sv ====
// Link-level assertions for the parallel PHY/MAC port
`timescale 1ns/100ps
module spp_link_monitor import spp_pkg::*; #(
   parameter int STAB_CYCLES = STAB_CYC
) (
   // Core reset
   input wire logic rst,
   // Transmit direction
   input wire logic mac_tx_clock,
   input wire logic detect_or_loopback_cmd,
   input wire logic tx_elec_idle_cmd,
   input wire logic power_state_bit0,
   input wire logic power_state_bit1,
   input wire logic phy_reset_n,
   // Receive direction
   input wire logic phy_rx_clock,
   input wire logic rx_symbols_valid,
   input wire logic op_done_flag
);
   // Settling bound in receive clock cycles
   localparam int SETTLE_MAX = STAB_CYCLES / 8 + 20;

   // Reset and standby levels driven by the MAC end
   AST_RESET_POWER:
   assert property (@(posedge mac_tx_clock) disable iff (rst)
      !phy_reset_n |-> {power_state_bit1, power_state_bit0} == 2'h2)
      else $error("power not deep standby in reset");
   AST_RESET_DETECT:
   assert property (@(posedge mac_tx_clock) disable iff (rst)
      !phy_reset_n |-> !detect_or_loopback_cmd)
      else $error("detect high in reset");
   AST_STANDBY_IDLE:
   assert property (@(posedge mac_tx_clock) disable iff (rst)
      (power_state_bit0 ^ power_state_bit1) |-> tx_elec_idle_cmd)
      else $error("transmit idle low in standby");
   // PHY end held in reset
   AST_RESET_DONE:
   assert property (@(posedge phy_rx_clock) disable iff (rst)
      !phy_reset_n && !$past(phy_reset_n, 3) |-> op_done_flag)
      else $error("done flag low in reset");
   AST_RESET_NO_VALID:
   assert property (@(posedge phy_rx_clock) disable iff (rst)
      !phy_reset_n && !$past(phy_reset_n, 3) |-> !rx_symbols_valid)
      else $error("valid high in reset");
   // Settling after reset release
   AST_SETTLE_HOLD:
   assert property (@(posedge phy_rx_clock) disable iff (rst)
      $rose(phy_reset_n) |-> op_done_flag [*2])
      else $error("done flag dropped early");
   AST_SETTLE_END:
   assert property (@(posedge phy_rx_clock) disable iff (rst)
      $rose(phy_reset_n) |-> ##[1:SETTLE_MAX] !op_done_flag)
      else $error("done flag never cleared");
   // Completion of commands
   AST_DETECT_DONE:
   assert property (@(posedge phy_rx_clock) disable iff (rst)
      $rose(detect_or_loopback_cmd) && power_state_bit1 && !power_state_bit0
      && phy_reset_n && !op_done_flag |-> ##[1:12] op_done_flag)
      else $error("detect not completed");
   AST_POWER_DONE:
   assert property (@(posedge phy_rx_clock) disable iff (rst)
      !$stable({power_state_bit1, power_state_bit0}) && phy_reset_n
      && $past(phy_reset_n, 8) |-> ##[1:12] op_done_flag)
      else $error("power change not completed");
endmodule
